// file: logic/ceb_pkg.sv
// Constants, register map and state layout of the embedded RAM block.
// Assumes one 20 MHz clock and a word-only AHB-Lite master.
`default_nettype none

package ceb_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int CEB_ROWS = 256;
	localparam int CEB_RW   = 16;
	localparam int CEB_AW   = 12;
	localparam int CEB_DW   = 32;
	localparam int CEB_NPIN = 11;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [31:0] CEB_OFF_CFG  = 32'h0000_0000;
	localparam logic [31:0] CEB_OFF_CSEL = 32'h0000_0004;
	localparam logic [31:0] CEB_OFF_GLOB = 32'h0000_0008;
	localparam logic [31:0] CEB_OFF_STAT = 32'h0000_000c;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CEB_CFG_SHAPE_LSB = 0;
	localparam int CEB_CFG_MODE_LSB  = 2;
	localparam int CEB_CSEL_INV_LSB  = 16;
	localparam int CEB_GLOB_LVL_LSB  = 4;
	localparam int CEB_STAT_CTL_LSB  = 4;
	localparam int CEB_STAT_LC_LSB   = 8;
	localparam int CEB_STAT_CLR_BIT  = 16;
	localparam int CEB_PIN_IO_LSB    = 6;
	localparam int CEB_PIN_CLR_BIT   = 10;

	// ------------------------------------------------------------
	// Reset values and source numbering
	// ------------------------------------------------------------
	localparam logic [1:0]  CEB_SHAPE_RST     = 2'h0;
	localparam logic [15:0] CEB_CSEL_RST      = 16'h0044;
	localparam logic [3:0]  CEB_CINV_RST      = 4'h0;
	localparam logic [3:0]  CEB_GEN_RST       = 4'h0;
	localparam logic [3:0]  CEB_GLVL_RST      = 4'h0;
	localparam logic [3:0]  CEB_SRC_FIRST_CLR = 4'h4;

	typedef enum logic [1:0] {CEB_SINGLE, CEB_WIDE, CEB_DEEP, CEB_DUAL} ceb_mode_e;

	typedef struct packed {
		logic [1:0]          shape;
		ceb_mode_e           mode;
		logic [15:0]         csel;
		logic [3:0]          cinv;
		logic [3:0]          gen;
		logic [3:0]          glvl;
		logic [CEB_NPIN-1:0] pin_s1;
		logic [CEB_NPIN-1:0] pin_s2;
		logic [CEB_NPIN-1:0] pin_s3;
		logic [CEB_NPIN-1:0] pin_f;
		logic [1:0]          ctl_prev;
		logic [CEB_AW-1:0]   ra_addr;
		logic [CEB_AW-1:0]   rb_addr;
		logic [CEB_DW-1:0]   a_rd;
		logic [CEB_DW-1:0]   b_rd;
		logic [7:0]          lc_q;
		logic                bus_act;
		logic                bus_wr;
		logic [31:0]         bus_addr;
		logic [31:0]         hrdata;
	} ceb_state_s;

endpackage : ceb_pkg

`default_nettype wire

// file: logic/ceb_ram_block.sv
// Embedded RAM block pair with cluster control routing and AHB-Lite registers.
// Assumes fabric ports are synchronous to clk_i; pins arrive asynchronously.
//
// Function
// R1: Each block takes one shape: 256x16, 512x8, 1024x4 or 2048x2.
// R2: Two same-shape blocks side by side share address, doubling word width.
// R3: Blocks cascade in depth; up to 2048 words with no extra latency. Here deep mode at 2048x2 reaches 4096 words.
// R4: Two blocks form a dual-port memory; both ports access in one cycle.
// R5: Input and output registers take independent clocks and clock enables.
// R6: All block registers clear on local, global or chip-wide clear.
// R7: Cluster offers four invertible controls to eight cells: two clocks, two clear/preset.
// R8: Cluster clocks come from dedicated clocks, globals, pin signals or local signals.
// R9: Cluster clear/preset come from globals, pin signals or local signals only.
// R10: Six dedicated inputs; four drive globals, which internal logic may drive instead.
// R11: Write stores word on input clock when write and clock enable; read returns it.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`default_nettype none

module ceb_ram_block (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// AHB-Lite slave
	input  wire logic                       hsel_i,
	input  wire logic [31:0]                haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [31:0]                hwdata_i,
	input  wire logic                       hready_i,
	output logic      [31:0]                hrdata_o,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	// Device pins
	input  wire logic [5:0]                 ded_i,
	input  wire logic [3:0]                 io_sig_i,
	input  wire logic                       dev_clr_i,
	// Cluster local signals and logic cells
	input  wire logic [3:0]                 loc_i,
	input  wire logic [7:0]                 lc_d_i,
	output logic      [7:0]                 lc_q_o,
	// Memory port A
	input  wire logic [ceb_pkg::CEB_AW-1:0] a_addr_i,
	input  wire logic [ceb_pkg::CEB_DW-1:0] a_wdata_i,
	input  wire logic                       a_we_i,
	input  wire logic                       a_ce_i,
	output logic      [ceb_pkg::CEB_DW-1:0] a_rdata_o,
	// Memory port B, dual mode only
	input  wire logic [ceb_pkg::CEB_AW-1:0] b_addr_i,
	input  wire logic [ceb_pkg::CEB_DW-1:0] b_wdata_i,
	input  wire logic                       b_we_i,
	input  wire logic                       b_ce_i,
	output logic      [ceb_pkg::CEB_DW-1:0] b_rdata_o,
	// Output register clock enable
	input  wire logic                       out_ce_i
);
	import ceb_pkg::*;

	// ------------------------------------------------------------
	// Word helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lane_mask(input logic [1:0] sh);
		case (sh)
			2'h0: lane_mask = 16'hffff;
			2'h1: lane_mask = 16'h00ff;
			2'h2: lane_mask = 16'h000f;
			default: lane_mask = 16'h0003;
		endcase
	endfunction : lane_mask

	function automatic logic [3:0] lane_pos(input logic [CEB_AW-1:0] a, input logic [1:0] sh);
		case (sh)
			2'h0: lane_pos = 4'h0;
			2'h1: lane_pos = {a[0], 3'h0};
			2'h2: lane_pos = {a[1:0], 2'h0};
			default: lane_pos = {a[2:0], 1'h0};
		endcase
	endfunction : lane_pos

	function automatic logic [15:0] get_word(input logic [15:0] row, input logic [1:0] sh, input logic [3:0] pos);
		get_word = (row >> pos) & lane_mask(sh);
	endfunction : get_word

	function automatic logic [15:0] put_word(input logic [15:0] row, input logic [1:0] sh,
		input logic [3:0] pos, input logic [15:0] d);
		put_word = (row & ~(lane_mask(sh) << pos)) | ((d & lane_mask(sh)) << pos);
	endfunction : put_word

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ceb_state_s s_reg;
	ceb_state_s s_next;
	logic [CEB_RW-1:0] mem [2][CEB_ROWS];

	logic [3:0]  glob;
	logic [15:0] src;
	logic [3:0]  ctl;
	logic        clr;
	logic        in_tick;
	logic        out_tick;
	logic        fa;
	logic        fb;
	logic        bus_take;
	logic [4:0]  wbits;
	logic        blk_wa;
	logic        blk_ra;
	logic [7:0]  row_wa;
	logic [7:0]  row_wb;
	logic [7:0]  row_ra;
	logic [7:0]  row_rb;
	logic [3:0]  pos_wa;
	logic [3:0]  pos_wb;
	logic [3:0]  pos_ra;
	logic [3:0]  pos_rb;
	logic        wa0;
	logic        wa1;
	logic [15:0] rd0;
	logic [15:0] rd1;
	logic [31:0] rda;
	logic [31:0] rdb;
	logic [31:0] reg_rd;

	// ------------------------------------------------------------
	// Control routing
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			glob[i] = s_reg.gen[i] ? s_reg.glvl[i] : s_reg.pin_f[i]; // R10
		end
		src = {loc_i, s_reg.pin_f[CEB_PIN_IO_LSB +: 4], glob, 2'h0, s_reg.pin_f[5:4]}; // R8
		for (int k = 0; k < 4; k++)
		begin
			ctl[k] = src[s_reg.csel[4*k +: 4]] ^ s_reg.cinv[k]; // R7
		end
		// Dedicated clock pins cannot reach the clear and preset controls
		for (int k = 2; k < 4; k++)
		begin
			if (s_reg.csel[4*k +: 4] < CEB_SRC_FIRST_CLR)
			begin
				ctl[k] = s_reg.cinv[k]; // R9
			end
		end
		clr = ctl[2] | s_reg.pin_f[CEB_PIN_CLR_BIT]; // R6
		in_tick = ctl[0] & ~s_reg.ctl_prev[0]; // R5
		out_tick = ctl[1] & ~s_reg.ctl_prev[1]; // R5
		fa = in_tick & a_ce_i & ~clr;
		fb = in_tick & b_ce_i & ~clr & (s_reg.mode == CEB_DUAL); // R4
	end

	// ------------------------------------------------------------
	// Memory addressing
	// ------------------------------------------------------------
	always_comb
	begin
		wbits = 5'(5'h10 >> s_reg.shape); // R1
		blk_wa = (s_reg.mode == CEB_DEEP) & a_addr_i[4'h8 + 4'(s_reg.shape)]; // R3
		blk_ra = (s_reg.mode == CEB_DEEP) & s_reg.ra_addr[4'h8 + 4'(s_reg.shape)];
		row_wa = 8'(a_addr_i >> s_reg.shape);
		row_wb = 8'(b_addr_i >> s_reg.shape);
		row_ra = 8'(s_reg.ra_addr >> s_reg.shape);
		row_rb = 8'(s_reg.rb_addr >> s_reg.shape);
		pos_wa = lane_pos(a_addr_i, s_reg.shape);
		pos_wb = lane_pos(b_addr_i, s_reg.shape);
		pos_ra = lane_pos(s_reg.ra_addr, s_reg.shape);
		pos_rb = lane_pos(s_reg.rb_addr, s_reg.shape);
		wa0 = ~blk_wa;
		wa1 = (s_reg.mode == CEB_WIDE) | (s_reg.mode == CEB_DUAL) | blk_wa; // R2
		rd0 = get_word(mem[0][row_ra], s_reg.shape, pos_ra);
		rd1 = get_word(mem[1][row_ra], s_reg.shape, pos_ra);
		rdb = 32'h0;
		case (s_reg.mode)
			CEB_WIDE: rda = ({16'h0, rd1} << wbits) | {16'h0, rd0}; // R2
			CEB_DEEP: rda = {16'h0, blk_ra ? rd1 : rd0}; // R3
			CEB_DUAL:
			begin
				rda = {16'h0, rd0};
				rdb = {16'h0, get_word(mem[1][row_rb], s_reg.shape, pos_rb)}; // R4
			end
			default: rda = {16'h0, rd0}; // R11
		endcase
	end

	// Contents survive clears; port B is written last, so it wins a shared row
	always_ff @(posedge clk_i)
	begin
		if (fa & a_we_i)
		begin
			if (wa0)
			begin
				mem[0][row_wa] <= put_word(mem[0][row_wa], s_reg.shape, pos_wa, a_wdata_i[15:0]); // R11
			end
			if (wa1)
			begin
				mem[1][row_wa] <= put_word(mem[1][row_wa], s_reg.shape, pos_wa,
					(s_reg.mode == CEB_WIDE) ? 16'(a_wdata_i >> wbits) : a_wdata_i[15:0]); // R2
			end
		end
		if (fb & b_we_i)
		begin
			mem[0][row_wb] <= put_word(mem[0][row_wb], s_reg.shape, pos_wb, b_wdata_i[15:0]); // R4
			mem[1][row_wb] <= put_word(mem[1][row_wb], s_reg.shape, pos_wb, b_wdata_i[15:0]); // R4
		end
	end

	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------
	always_comb
	begin
		if (haddr_i == CEB_OFF_CFG)
		begin
			reg_rd = {28'h0, s_reg.mode, s_reg.shape};
		end
		else if (haddr_i == CEB_OFF_CSEL)
		begin
			reg_rd = {12'h0, s_reg.cinv, s_reg.csel};
		end
		else if (haddr_i == CEB_OFF_GLOB)
		begin
			reg_rd = {24'h0, s_reg.glvl, s_reg.gen};
		end
		else if (haddr_i == CEB_OFF_STAT)
		begin
			reg_rd = {15'h0, clr, s_reg.lc_q, ctl, glob};
		end
		else
		begin
			reg_rd = 32'h0;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		bus_take = hsel_i & htrans_i[1] & hready_i;
		// Three stages; a pin change counts once stages two and three agree
		s_next.pin_s1 = {dev_clr_i, io_sig_i, ded_i};
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.pin_s3 = s_reg.pin_s2;
		s_next.pin_f = s_reg.pin_f;
		for (int i = 0; i < CEB_NPIN; i++)
		begin
			if (s_reg.pin_s2[i] == s_reg.pin_s3[i])
			begin
				s_next.pin_f[i] = s_reg.pin_s3[i];
			end
		end
		s_next.ctl_prev = ctl[1:0];
		s_next.bus_act = bus_take;
		if (bus_take)
		begin
			s_next.bus_wr = hwrite_i;
			s_next.bus_addr = haddr_i;
			s_next.hrdata = hwrite_i ? s_reg.hrdata : reg_rd;
		end
		if (s_reg.bus_act & s_reg.bus_wr)
		begin
			if (s_reg.bus_addr == CEB_OFF_CFG)
			begin
				s_next.shape = hwdata_i[CEB_CFG_SHAPE_LSB +: 2]; // R1
				s_next.mode = ceb_mode_e'(hwdata_i[CEB_CFG_MODE_LSB +: 2]);
			end
			else if (s_reg.bus_addr == CEB_OFF_CSEL)
			begin
				s_next.csel = hwdata_i[15:0]; // R8
				s_next.cinv = hwdata_i[CEB_CSEL_INV_LSB +: 4]; // R7
			end
			else if (s_reg.bus_addr == CEB_OFF_GLOB)
			begin
				s_next.gen = hwdata_i[3:0]; // R10
				s_next.glvl = hwdata_i[CEB_GLOB_LVL_LSB +: 4];
			end
		end
		// Block input and output registers
		if (clr)
		begin
			s_next.ra_addr = '0; // R6
			s_next.rb_addr = '0;
			s_next.a_rd = '0;
			s_next.b_rd = '0;
		end
		else
		begin
			if (fa)
			begin
				s_next.ra_addr = a_addr_i; // R5
			end
			if (fb)
			begin
				s_next.rb_addr = b_addr_i;
			end
			if (out_tick & out_ce_i)
			begin
				s_next.a_rd = rda; // R5
				s_next.b_rd = rdb;
			end
		end
		// Cluster logic cells on cluster clock 0
		if (clr)
		begin
			s_next.lc_q = 8'h00; // R7
		end
		else if (ctl[3])
		begin
			s_next.lc_q = 8'hff; // R7
		end
		else if (in_tick)
		begin
			s_next.lc_q = lc_d_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_reg <= '0;
			s_reg.shape <= CEB_SHAPE_RST;
			s_reg.mode <= CEB_SINGLE;
			s_reg.csel <= CEB_CSEL_RST;
			s_reg.cinv <= CEB_CINV_RST;
			s_reg.gen <= CEB_GEN_RST;
			s_reg.glvl <= CEB_GLVL_RST;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign hrdata_o = s_reg.hrdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign lc_q_o = s_reg.lc_q;
	assign a_rdata_o = s_reg.a_rd;
	assign b_rdata_o = s_reg.b_rd;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic        chk_v;
	logic [7:0]  chk_row;
	logic [3:0]  chk_pos;
	logic [15:0] chk_data;

	always_ff @(posedge clk_i)
	begin
		chk_v <= fa & a_we_i & ~fb & (s_reg.mode == CEB_SINGLE);
		chk_row <= row_wa;
		chk_pos <= pos_wa;
		chk_data <= a_wdata_i[15:0] & lane_mask(s_reg.shape);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cfg_wr;
		bus_take && hwrite_i && haddr_i == CEB_OFF_CFG ##1 1'b1;
	endsequence

	sequence s_out_load;
		out_tick && out_ce_i && !clr;
	endsequence

	a_cfg_write: assert property (s_cfg_wr |=> {s_reg.mode, s_reg.shape} == $past(hwdata_i[3:0])) // R1
		else $error("shape or mode not taken from bus write");
	a_store_word: assert property (chk_v |-> get_word(mem[0][chk_row], s_reg.shape, chk_pos) == chk_data) // R11
		else $error("written word not found in memory");
	a_single_width: assert property ((s_out_load and (s_reg.mode == CEB_SINGLE)) |=>
		(a_rdata_o >> $past(wbits)) == 32'h0) // R1
		else $error("single read wider than shape");
	a_wide_width: assert property ((s_out_load and (s_reg.mode == CEB_WIDE)) |=>
		(a_rdata_o >> ($past(wbits) * 2)) == 32'h0) // R2
		else $error("wide read exceeds twice the shape width");
	a_clear_regs: assert property (clr |=> a_rdata_o == 32'h0 && b_rdata_o == 32'h0 && lc_q_o == 8'h00) // R6
		else $error("clear left a register set");
	a_out_hold: assert property (!(out_tick && out_ce_i) && !clr |=> $stable(a_rdata_o)) // R5
		else $error("output register moved without its clock");
	a_preset_cells: assert property (ctl[3] && !clr |=> lc_q_o == 8'hff) // R7
		else $error("preset did not set logic cells");
	a_glob_drive: assert property (s_reg.gen[0] |-> glob[0] == s_reg.glvl[0]) // R10
		else $error("global not driven by internal level");
	a_no_ded_clear: assert property (s_reg.csel[11:8] < CEB_SRC_FIRST_CLR |-> ctl[2] == s_reg.cinv[2]) // R9
		else $error("dedicated clock reached clear control");
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("slave stalled or erred");

endmodule : ceb_ram_block

`default_nettype wire

// file: bench/ceb_fab_model.sv
// Fabric-side user logic that drives memory port A and the local control lines.
// Assumes the block samples these on clk_i; loc_o[0] is the input/output clock source.
`default_nettype none

module ceb_fab_model (
	// Clock
	input  wire logic                       clk_i,
	// Local control lines
	output logic      [3:0]                 loc_o,
	// Memory port A
	output logic      [ceb_pkg::CEB_AW-1:0] a_addr_o,
	output logic      [ceb_pkg::CEB_DW-1:0] a_wdata_o,
	output logic                            a_we_o,
	output logic                            a_ce_o,
	output logic                            out_ce_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import ceb_pkg::*;

	initial
	begin
		loc_o     = 4'h0;
		a_addr_o  = '0;
		a_wdata_o = '0;
		a_we_o    = 1'b0;
		a_ce_o    = 1'b0;
		out_ce_o  = 1'b0;
	end

	// ------------------------------------------------------------
	// One clock tick on loc_o[0], two cycles long
	// ------------------------------------------------------------
	task automatic tick(input logic ce, input logic we, input logic [CEB_AW-1:0] ad,
		input logic [CEB_DW-1:0] d, input logic oce);
		loc_o[0]  <= 1'b1;
		a_ce_o    <= ce;
		a_we_o    <= we;
		a_addr_o  <= ad;
		a_wdata_o <= d;
		out_ce_o  <= oce;
		@(posedge clk_i);
		// Released lines show inverted garbage, not the last value
		loc_o[0]  <= 1'b0;
		a_ce_o    <= 1'b0;
		a_we_o    <= 1'b0;
		a_addr_o  <= ~ad;
		a_wdata_o <= ~d;
		out_ce_o  <= 1'b0;
		@(posedge clk_i);
	endtask : tick

	task automatic clr(input logic v);
		loc_o[1] <= v;
		@(posedge clk_i);
	endtask : clr

endmodule : ceb_fab_model

`default_nettype wire

// file: bench/configurable_embedded_ram_block_tb_top.sv
// Self-checking bench for the embedded RAM block: AHB-Lite master and fabric model.
// Assumes hreadyout is the bus's hready; the bench drives port B itself in dual mode.
`default_nettype none

module configurable_embedded_ram_block_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ceb_pkg::*;

	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              hsel = 1'b0;
	logic       [31:0] haddr = '0;
	logic       [1:0]  htrans = 2'h0;
	logic              hwrite = 1'b0;
	logic       [2:0]  hsize = 3'h0;
	logic [CEB_AW-1:0] b_addr = '0;
	logic [CEB_DW-1:0] b_wdata = '0;
	logic              b_we = 1'b0;
	logic              b_ce = 1'b0;
	logic       [31:0] hwdata = '0;
	logic       [31:0] hrdata;
	logic              hready;
	logic              hresp;
	logic       [5:0]  ded = 6'h00;
	logic       [3:0]  io_sig = 4'h0;
	logic              dev_clr = 1'b0;
	logic       [7:0]  lc_d = 8'h00;
	logic       [7:0]  lc_q;
	logic       [3:0]  loc;
	logic [CEB_AW-1:0] a_addr;
	logic [CEB_DW-1:0] a_wdata;
	logic [CEB_DW-1:0] a_rdata;
	logic [CEB_DW-1:0] b_rdata;
	logic              a_we;
	logic              a_ce;
	logic              out_ce;
	int                failures = 0;
	int                n_tests = 0;
	int                cyc = 0;

	always #25 clk_i = ~clk_i;

	ceb_ram_block i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .ded_i(ded),
		.io_sig_i(io_sig), .dev_clr_i(dev_clr), .loc_i(loc), .lc_d_i(lc_d), .lc_q_o(lc_q),
		.a_addr_i(a_addr), .a_wdata_i(a_wdata), .a_we_i(a_we), .a_ce_i(a_ce),
		.a_rdata_o(a_rdata), .b_addr_i(b_addr), .b_wdata_i(b_wdata), .b_we_i(b_we), .b_ce_i(b_ce),
		.b_rdata_o(b_rdata), .out_ce_i(out_ce)
	);

	ceb_fab_model i_fab (
		.clk_i(clk_i), .loc_o(loc), .a_addr_o(a_addr), .a_wdata_o(a_wdata),
		.a_we_o(a_we), .a_ce_o(a_ce), .out_ce_o(out_ce)
	);

	// ------------------------------------------------------------
	// Expectations and checks
	// ------------------------------------------------------------
	function automatic int wdt(int m, int s);
		return (16 >> s) * ((m == 1) ? 2 : 1);
	endfunction : wdt

	function automatic int dep(int m, int s);
		return (256 << s) * ((m == 2) ? 2 : 1);
	endfunction : dep

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// Single word transfer; waits on hready, never a fixed count
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'h2;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0]       r;
		logic [CEB_AW-1:0] ad [2];
		logic [31:0]       dt [2];
		logic [31:0]       mk;
		int                dp;
		void'($urandom(32'he9b9));
		lc_d <= 8'($urandom);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		ahb(1'b0, CEB_OFF_CFG, 32'h0, r); chk(r, 32'h0);
		ahb(1'b0, CEB_OFF_CSEL, 32'h0, r); chk(r, 32'h44);
		ahb(1'b0, CEB_OFF_GLOB, 32'h0, r); chk(r, 32'h0);
		ahb(1'b0, 32'h10, 32'h0, r); chk(r, 32'h0);
		$display("test reset values done");
		ahb(1'b1, CEB_OFF_CSEL, 32'hcc, r);
		for (int m = 0; m < 4; m++)
		begin
			for (int s = 0; s < 4; s++)
			begin
				ahb(1'b1, CEB_OFF_CFG, 32'(m * 4 + s), r);
				@(posedge clk_i);
				dp    = dep(m, s);
				mk    = 32'hffff_ffff >> (32 - wdt(m, s));
				ad[0] = CEB_AW'($urandom % (dp / 2));
				ad[1] = CEB_AW'(dp - 1);
				for (int i = 0; i < 2; i++)
				begin
					dt[i] = $urandom;
					i_fab.tick(1'b1, 1'b1, ad[i], dt[i], 1'b0);
				end
				for (int i = 0; i < 2; i++)
				begin
					i_fab.tick(1'b1, 1'b0, ad[i], '0, 1'b0);
					i_fab.tick(1'b0, 1'b0, '0, '0, 1'b1);
					chk(a_rdata & mk, dt[i] & mk);
				end
				i_fab.tick(1'b1, 1'b0, ad[0], '0, 1'b0);
				i_fab.tick(1'b0, 1'b0, '0, '0, 1'b0);
				chk(a_rdata & mk, dt[1] & mk);
			end
		end
		$display("test shapes and modes done");
		// Still dual 2048x2: both ports write other rows in one tick, then cross-read
		b_addr  <= ad[0] ^ 12'h8;
		b_wdata <= 32'h2;
		b_we    <= 1'b1;
		b_ce    <= 1'b1;
		i_fab.tick(1'b1, 1'b1, ad[0], 32'h1, 1'b0);
		b_addr  <= ad[0];
		b_we    <= 1'b0;
		i_fab.tick(1'b1, 1'b0, ad[0] ^ 12'h8, '0, 1'b0);
		b_ce    <= 1'b0;
		i_fab.tick(1'b0, 1'b0, '0, '0, 1'b1);
		chk(a_rdata, 32'h2);
		chk(b_rdata, 32'h1);
		chk(lc_q, lc_d);
		$display("test dual port done");
		ahb(1'b1, CEB_OFF_CSEL, 32'h0dcc, r);
		i_fab.clr(1'b1);
		repeat (2) @(posedge clk_i);
		chk(a_rdata, 32'h0);
		i_fab.clr(1'b0);
		// Reload a nonzero word so the chip-wide clear has something to clear
		i_fab.tick(1'b1, 1'b0, ad[0] ^ 12'h8, '0, 1'b0);
		i_fab.tick(1'b0, 1'b0, '0, '0, 1'b1);
		chk(a_rdata, 32'h2);
		dev_clr <= 1'b1;
		repeat (8) @(posedge clk_i);
		ahb(1'b0, CEB_OFF_STAT, 32'h0, r);
		chk(r[CEB_STAT_CLR_BIT], 1'b1);
		chk(a_rdata, 32'h0);
		dev_clr <= 1'b0;
		$display("test clears done");
		ahb(1'b1, CEB_OFF_GLOB, 32'h5f, r);
		repeat (2) @(posedge clk_i);
		ahb(1'b0, CEB_OFF_STAT, 32'h0, r);
		chk(r[3:0], 4'h5);
		ahb(1'b1, CEB_OFF_GLOB, 32'h0, r);
		ded <= 6'($urandom);
		repeat (8) @(posedge clk_i);
		ahb(1'b0, CEB_OFF_STAT, 32'h0, r);
		chk(r[3:0], ded[3:0]);
		$display("test globals done");
		// Clear from inverted pin signal; preset selects a dedicated clock source, so it holds its inversion bit
		ahb(1'b1, CEB_OFF_CSEL, 32'h000c_18cc, r);
		io_sig <= 4'h1;
		repeat (8) @(posedge clk_i);
		ahb(1'b0, CEB_OFF_STAT, 32'h0, r);
		chk(r[7:4], 4'b1000);
		chk(r[15:8], 8'hff);
		io_sig <= 4'h0;
		repeat (8) @(posedge clk_i);
		ahb(1'b0, CEB_OFF_STAT, 32'h0, r);
		chk(r[7:4], 4'b1100);
		chk(lc_q, 8'h00);
		chk(r[CEB_STAT_CLR_BIT], 1'b1);
		$display("test cluster controls done");
		final_report();
	end

endmodule : configurable_embedded_ram_block_tb_top

`default_nettype wire
